/* File: core/ptm_tick.sv */
`timescale 1ns/1ps
// ****************************************************************
// Counter tick source: prescalers and external edge detect
// ****************************************************************
module ptm_tick (
	input wire logic sys_clk, // System clock
	input wire logic rst, // Sync reset, high
	input wire logic [2:0] clock_select, // Source choice
	input wire logic high_speed_tick, // High clock strobe
	input wire logic sub_clock, // Async sub clock level
	input wire logic external_count_input, // Async pin
	output logic tick // One-cycle count enable
);
	logic [1:0] div_r;
	logic [2:0] ext_sync_r;
	logic [2:0] sub_sync_r;
	logic [5:0] hdiv_r;
	logic hpulse;
	logic ext_rise;
	logic ext_fall;
	logic sub_rise;

	// Two stages then edge register; edge logic reads stages 2 and 3
	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			ext_sync_r <= 3'h0;
			sub_sync_r <= 3'h0;
		end
		else
		begin
			ext_sync_r <= {ext_sync_r[1:0], external_count_input};
			sub_sync_r <= {sub_sync_r[1:0], sub_clock};
		end
	end

	assign ext_rise = ext_sync_r[1] & ~ext_sync_r[2];
	assign ext_fall = ~ext_sync_r[1] & ext_sync_r[2];
	assign sub_rise = sub_sync_r[1] & ~sub_sync_r[2];

	// Free-running system prescaler
	always_ff @(posedge sys_clk)
	begin
		if (rst)
			div_r <= 2'h0;
		else
			div_r <= div_r + 2'h1;
	end

	// High clock prescaler, advanced by its strobe
	always_ff @(posedge sys_clk)
	begin
		if (rst)
			hdiv_r <= 6'h00;
		else if (high_speed_tick)
			hdiv_r <= hdiv_r + 6'h01;
	end

	assign hpulse = high_speed_tick;

	// Source mux
	always_comb
	begin
		case (clock_select)
			ptm_pkg::CKS_SYS4: tick = (div_r == 2'(ptm_pkg::DIV_SYS4 - 1));
			ptm_pkg::CKS_SYS: tick = 1'b1;
			ptm_pkg::CKS_H16: tick = hpulse
				& (hdiv_r[3:0] == 4'(ptm_pkg::DIV_H16 - 1));
			ptm_pkg::CKS_H64: tick = hpulse
				& (hdiv_r == 6'(ptm_pkg::DIV_H64 - 1));
			ptm_pkg::CKS_SUB0, ptm_pkg::CKS_SUB1: tick = sub_rise;
			ptm_pkg::CKS_EXTR: tick = ext_rise;
			ptm_pkg::CKS_EXTF: tick = ext_fall;
			default: tick = 1'b0;
		endcase
	end
endmodule

/* File: core/ptm_top.sv */
`timescale 1ns/1ps
// ****************************************************************
// Periodic timer
// ****************************************************************
// Contract
// - 16-bit up counter ticked by selected internal clock or pin edge.
// - Comparators A and P compare all counter bits, signal match.
// - Software cannot write counter; only on rising edge clears it.
// - Counter clears on overflow or selected compare match, with flag.
// - Control0 bit 7 pauses counter; holds value, resumes from it.
// - Clock select bits 6..4 choose among seven sources; codes 4 and 5 both pick the sub clock.
// - Control0 bit 3 on/off; off holds count, rising edge zeroes.
// - On rising edge resets output to initial level in output modes.
// - Control0 bits 2..0 read as zero.
// - Control1 bits 7..6 pick compare, PWM/pulse or timer mode.
// - Compare mode A match: keep, low, high or toggle output.
// - PWM mode pin function: inactive, active, PWM, single pulse.
// - Requested level equal to current level shows no change.
// - Output level bit sets initial level or PWM active sense.
// - Invert bit inverts main output; no effect in timer mode.
// - Complementary pin is inverse of main output.
// - Clear select: 0 P match or overflow, 1 A match.
// - Overflow clear with P source only when P value is zero.
// - Counter read-only byte pair; compare pairs read/write; reset zero.
// - Only A match or on rising edge changes output in compare mode.
// - With A as clear source, no P flag is raised.
// - PWM: P sets period, zero means 65536; A duty, saturates 100%.
module ptm_top (
	input wire logic sys_clk, // System clock
	input wire logic rst, // Sync reset, high
	input wire logic [2:0] reg_addr, // Register index
	input wire logic [7:0] reg_wdata, // Write data
	input wire logic reg_wr, // Write strobe
	input wire logic reg_rd, // Read strobe
	output logic [7:0] reg_rdata, // Read data, next cycle
	input wire logic high_speed_tick, // High clock strobe
	input wire logic sub_clock, // Sub clock level
	input wire logic external_count_input, // Count pin
	output logic timer_output, // Main output pin
	output logic timer_output_inverted, // Inverse pin
	output logic compare_a_flag, // A match pulse
	output logic compare_p_flag // P match pulse
);
	logic [7:0] ctrl0_r;
	logic [7:0] ctrl1_r;
	logic [15:0] cnt_r;
	logic [15:0] cmpa_r;
	logic [15:0] cmpp_r;
	logic on_d_r;
	logic out_r;
	logic pulse_off;
	logic tick;
	logic on_rise;
	logic run;
	logic match_a;
	logic match_p;
	logic ovf;
	logic clr_cnt;
	logic is_pwm;
	logic pwm_level;
	logic out_nxt;
	logic [1:0] mode;
	logic [1:0] pinf;

	assign mode = ctrl1_r[ptm_pkg::C1_MODE_HI:ptm_pkg::C1_MODE_LO];
	assign pinf = ctrl1_r[ptm_pkg::C1_IO_HI:ptm_pkg::C1_IO_LO];
	assign is_pwm = (mode == ptm_pkg::MODE_PWM);

	// Tick generator
	ptm_tick u_tick (
		.sys_clk(sys_clk),
		.rst(rst),
		.clock_select(ctrl0_r[ptm_pkg::C0_CKS_HI:ptm_pkg::C0_CKS_LO]),
		.high_speed_tick(high_speed_tick),
		.sub_clock(sub_clock),
		.external_count_input(external_count_input),
		.tick(tick)
	);

	// ****************************************************************
	// Register file
	// ****************************************************************

	// Control 0; single pulse end clears the on bit itself
	always_ff @(posedge sys_clk)
	begin
		if (rst)
			ctrl0_r <= ptm_pkg::CTRL_RESET;
		else if (reg_wr && reg_addr == ptm_pkg::OFS_CTRL0)
			ctrl0_r <= reg_wdata & ptm_pkg::C0_WMASK;
		else if (pulse_off)
			ctrl0_r[ptm_pkg::C0_ON] <= 1'b0;
	end

	// Control 1 and compare registers
	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			ctrl1_r <= ptm_pkg::CTRL_RESET;
			cmpa_r <= 16'h0000;
			cmpp_r <= 16'h0000;
		end
		else if (reg_wr)
		begin
			case (reg_addr)
				ptm_pkg::OFS_CTRL1: ctrl1_r <= reg_wdata;
				ptm_pkg::OFS_CMPA_LO: cmpa_r[7:0] <= reg_wdata;
				ptm_pkg::OFS_CMPA_HI: cmpa_r[15:8] <= reg_wdata;
				ptm_pkg::OFS_CMPP_LO: cmpp_r[7:0] <= reg_wdata;
				ptm_pkg::OFS_CMPP_HI: cmpp_r[15:8] <= reg_wdata;
				default: ;
			endcase
		end
	end

	// Read port; counter bytes have no write path
	always_ff @(posedge sys_clk)
	begin
		if (rst)
			reg_rdata <= 8'h00;
		else if (reg_rd)
		begin
			case (reg_addr)
				ptm_pkg::OFS_CTRL0: reg_rdata <= ctrl0_r;
				ptm_pkg::OFS_CTRL1: reg_rdata <= ctrl1_r;
				ptm_pkg::OFS_CNT_LO: reg_rdata <= cnt_r[7:0];
				ptm_pkg::OFS_CNT_HI: reg_rdata <= cnt_r[15:8];
				ptm_pkg::OFS_CMPA_LO: reg_rdata <= cmpa_r[7:0];
				ptm_pkg::OFS_CMPA_HI: reg_rdata <= cmpa_r[15:8];
				ptm_pkg::OFS_CMPP_LO: reg_rdata <= cmpp_r[7:0];
				default: reg_rdata <= cmpp_r[15:8];
			endcase
		end
		else
			reg_rdata <= 8'h00;
	end

	// ****************************************************************
	// Counter
	// ****************************************************************

	assign on_rise = ctrl0_r[ptm_pkg::C0_ON] & ~on_d_r;
	// Pause and off both freeze the count
	assign run = ctrl0_r[ptm_pkg::C0_ON] & ~ctrl0_r[ptm_pkg::C0_PAUSE]
		& ~on_rise & tick;
	// Full 16-bit compares, evaluated on the tick that reaches the value
	assign match_a = run && (cnt_r + 16'h0001 == cmpa_r)
		&& (cmpa_r != 16'h0000);
	assign match_p = run && (cnt_r + 16'h0001 == cmpp_r)
		&& (cmpp_r != 16'h0000);
	assign ovf = run && (cnt_r == 16'hFFFF);

	// Clear source choice; PWM and pulse always use P for period
	always_comb
	begin
		if (is_pwm)
			clr_cnt = match_p | (ovf & (cmpp_r == 16'h0000));
		else if (ctrl1_r[ptm_pkg::C1_CCLR])
			clr_cnt = match_a | ovf;
		else
			clr_cnt = match_p | (ovf & (cmpp_r == 16'h0000));
	end

	// Remembers previous on bit for edge detection
	always_ff @(posedge sys_clk)
	begin
		if (rst)
			on_d_r <= 1'b0;
		else
			on_d_r <= ctrl0_r[ptm_pkg::C0_ON];
	end

	// Counter update; cleared only by hardware events or on rising edge
	always_ff @(posedge sys_clk)
	begin
		if (rst)
			cnt_r <= 16'h0000;
		else if (on_rise)
			cnt_r <= 16'h0000;
		else if (run)
			cnt_r <= clr_cnt ? 16'h0000 : cnt_r + 16'h0001;
	end

	// Match flags, one cycle each
	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			compare_a_flag <= 1'b0;
			compare_p_flag <= 1'b0;
		end
		else
		begin
			compare_a_flag <= match_a;
			compare_p_flag <= match_p & (is_pwm
				| ~ctrl1_r[ptm_pkg::C1_CCLR]);
		end
	end

	// ****************************************************************
	// Output pin
	// ****************************************************************

	// Single pulse ends on A match, which also drops the on bit
	assign pulse_off = is_pwm && pinf == ptm_pkg::IO_11 && match_a;

	// Active when count below duty; duty at or above period saturates
	assign pwm_level = (cnt_r < cmpa_r)
		|| (cmpp_r != 16'h0000 && cmpa_r >= cmpp_r);

	// Internal level before inversion, per mode
	always_comb
	begin
		out_nxt = out_r;
		if (on_rise && mode != ptm_pkg::MODE_TMR)
			out_nxt = ctrl1_r[ptm_pkg::C1_OC];
		else if (mode == ptm_pkg::MODE_CMP && match_a)
		begin
			case (pinf)
				ptm_pkg::IO_01: out_nxt = 1'b0;
				ptm_pkg::IO_10: out_nxt = 1'b1;
				ptm_pkg::IO_11: out_nxt = ~out_r;
				default: out_nxt = out_r;
			endcase
		end
		else if (is_pwm)
		begin
			case (pinf)
				ptm_pkg::IO_00: out_nxt = ~ctrl1_r[ptm_pkg::C1_OC];
				ptm_pkg::IO_01: out_nxt = ctrl1_r[ptm_pkg::C1_OC];
				ptm_pkg::IO_10: out_nxt = pwm_level
					? ctrl1_r[ptm_pkg::C1_OC] : ~ctrl1_r[ptm_pkg::C1_OC];
				default: out_nxt = (pulse_off
					|| !ctrl0_r[ptm_pkg::C0_ON])
					? ~ctrl1_r[ptm_pkg::C1_OC] : out_r;
			endcase
		end
	end

	// Output register; pins are direct flops, polarity applied at load
	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			out_r <= 1'b0;
			timer_output <= 1'b0;
			timer_output_inverted <= 1'b1;
		end
		else
		begin
			out_r <= out_nxt;
			// Polarity ignored in timer mode, where pin is undefined
			timer_output <= out_nxt ^ (ctrl1_r[ptm_pkg::C1_POL]
				& (mode != ptm_pkg::MODE_TMR));
			timer_output_inverted <= ~(out_nxt
				^ (ctrl1_r[ptm_pkg::C1_POL] & (mode != ptm_pkg::MODE_TMR)));
		end
	end

	// ****************************************************************
	// Assertions
	// ****************************************************************

	property p_pins_inverse;
		@(posedge sys_clk) disable iff (rst)
		timer_output_inverted == ~timer_output;
	endproperty
	a_pins_inverse: assert property (p_pins_inverse)
		else $error("complementary pin not inverse");

	property p_on_clears;
		@(posedge sys_clk) disable iff (rst)
		on_rise |=> cnt_r == 16'h0000;
	endproperty
	a_on_clears: assert property (p_on_clears)
		else $error("on edge did not clear counter");

	property p_pause_holds;
		@(posedge sys_clk) disable iff (rst)
		ctrl0_r[ptm_pkg::C0_PAUSE] && !on_rise |=> $stable(cnt_r);
	endproperty
	a_pause_holds: assert property (p_pause_holds)
		else $error("counter moved while paused");

	property p_no_p_flag;
		@(posedge sys_clk) disable iff (rst)
		ctrl1_r[ptm_pkg::C1_CCLR] && !is_pwm |=> !compare_p_flag;
	endproperty
	a_no_p_flag: assert property (p_no_p_flag)
		else $error("P flag with A clear source");

	property p_flag_single;
		@(posedge sys_clk) disable iff (rst)
		compare_a_flag && cmpa_r != 16'h0001 |=> !compare_a_flag;
	endproperty
	a_flag_single: assert property (p_flag_single)
		else $error("A flag longer than a cycle");

	property p_match_clears;
		@(posedge sys_clk) disable iff (rst)
		match_p && !is_pwm && !ctrl1_r[ptm_pkg::C1_CCLR]
		|=> cnt_r == 16'h0000 && compare_p_flag;
	endproperty
	a_match_clears: assert property (p_match_clears)
		else $error("P match did not clear counter");

	property p_init_level;
		@(posedge sys_clk) disable iff (rst)
		on_rise && mode == ptm_pkg::MODE_CMP
		|=> out_r == $past(ctrl1_r[ptm_pkg::C1_OC]);
	endproperty
	a_init_level: assert property (p_init_level)
		else $error("output not set to initial level");

	property p_no_change;
		@(posedge sys_clk) disable iff (rst)
		mode == ptm_pkg::MODE_CMP && !on_rise && !match_a
		|=> $stable(out_r);
	endproperty
	a_no_change: assert property (p_no_change)
		else $error("output moved without A match");

	property p_ctrl0_low;
		@(posedge sys_clk) disable iff (rst)
		reg_rd && reg_addr == ptm_pkg::OFS_CTRL0 |=> reg_rdata[2:0] == 3'h0;
	endproperty
	a_ctrl0_low: assert property (p_ctrl0_low)
		else $error("unimplemented bits read nonzero");

	// Duty at or above a nonzero period must hold the active level
	property p_pwm_full;
		@(posedge sys_clk) disable iff (rst)
		is_pwm && pinf == ptm_pkg::IO_10 && cmpp_r != 16'h0000
		&& cmpa_r >= cmpp_r |=> out_r == $past(ctrl1_r[ptm_pkg::C1_OC]);
	endproperty
	a_pwm_full: assert property (p_pwm_full)
		else $error("duty at or above period not full");

	// Pulse end drops the on bit unless software writes it that cycle
	property p_pulse_stops;
		@(posedge sys_clk) disable iff (rst)
		pulse_off && !(reg_wr && reg_addr == ptm_pkg::OFS_CTRL0)
		|=> !ctrl0_r[ptm_pkg::C0_ON];
	endproperty
	a_pulse_stops: assert property (p_pulse_stops)
		else $error("single pulse did not stop counter");

	c_a_match: cover property (@(posedge sys_clk) compare_a_flag);
	c_p_match: cover property (@(posedge sys_clk) compare_p_flag);
	c_on_rise: cover property (@(posedge sys_clk) on_rise);
	c_pulse: cover property (@(posedge sys_clk) pulse_off);
endmodule

/* File: shared/ptm_pkg.sv */
// ****************************************************************
// Periodic timer constants
// ****************************************************************
package ptm_pkg;
	localparam int ADDR_W = 3;
	localparam int CNT_W = 16;
	// Register indices
	localparam logic [2:0] OFS_CTRL0 = 3'h0;
	localparam logic [2:0] OFS_CTRL1 = 3'h1;
	localparam logic [2:0] OFS_CNT_LO = 3'h2;
	localparam logic [2:0] OFS_CNT_HI = 3'h3;
	localparam logic [2:0] OFS_CMPA_LO = 3'h4;
	localparam logic [2:0] OFS_CMPA_HI = 3'h5;
	localparam logic [2:0] OFS_CMPP_LO = 3'h6;
	localparam logic [2:0] OFS_CMPP_HI = 3'h7;
	// Control 0 fields
	localparam int C0_PAUSE = 7;
	localparam int C0_CKS_HI = 6;
	localparam int C0_CKS_LO = 4;
	localparam int C0_ON = 3;
	localparam logic [7:0] C0_WMASK = 8'hF8;
	// Control 1 fields
	localparam int C1_MODE_HI = 7;
	localparam int C1_MODE_LO = 6;
	localparam int C1_IO_HI = 5;
	localparam int C1_IO_LO = 4;
	localparam int C1_OC = 3;
	localparam int C1_POL = 2;
	localparam int C1_CCLR = 0;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	// Modes
	localparam logic [1:0] MODE_CMP = 2'h0;
	localparam logic [1:0] MODE_PWM = 2'h2;
	localparam logic [1:0] MODE_TMR = 2'h3;
	// Pin functions
	localparam logic [1:0] IO_00 = 2'h0;
	localparam logic [1:0] IO_01 = 2'h1;
	localparam logic [1:0] IO_10 = 2'h2;
	localparam logic [1:0] IO_11 = 2'h3;
	// Clock selects
	localparam logic [2:0] CKS_SYS4 = 3'h0;
	localparam logic [2:0] CKS_SYS = 3'h1;
	localparam logic [2:0] CKS_H16 = 3'h2;
	localparam logic [2:0] CKS_H64 = 3'h3;
	localparam logic [2:0] CKS_SUB0 = 3'h4;
	localparam logic [2:0] CKS_SUB1 = 3'h5;
	localparam logic [2:0] CKS_EXTR = 3'h6;
	localparam logic [2:0] CKS_EXTF = 3'h7;
	// Prescale divisors
	localparam int DIV_SYS4 = 4;
	localparam int DIV_H16 = 16;
	localparam int DIV_H64 = 64;
endpackage

/* File: tb/periodic_timer_module_tb.sv */
`timescale 1ns/1ps
// ****
// Self-checking bench for the periodic timer
// ****
module periodic_timer_module_tb;
	typedef struct packed {logic [2:0] a; logic [7:0] d; logic [7:0] e;}
		ptm_row_t;
	typedef struct packed {logic [7:0] c1; logic [15:0] a; int hi;}
		ptm_pwm_t;
	logic sys_clk, rst, reg_wr, reg_rd;
	logic [2:0] reg_addr;
	logic [7:0] reg_wdata, reg_rdata, rv, rv2;
	logic high_speed_tick, sub_clock, external_count_input;
	logic timer_output, timer_output_inverted, compare_a_flag, compare_p_flag;
	logic po, pa, pp;
	int n_errors, num_checks, na, np, nhi, ntg, nbad;
	// Writes then read-backs; counter and low ctrl0 bits must not stick
	ptm_row_t rows[8] = '{'{3'h4, 8'h5A, 8'h5A}, '{3'h5, 8'hC3, 8'hC3},
		'{3'h6, 8'h81, 8'h81}, '{3'h7, 8'h7E, 8'h7E},
		'{3'h1, 8'hF9, 8'hF9}, '{3'h0, 8'h07, 8'h00},
		'{3'h2, 8'hFF, 8'h00}, '{3'h3, 8'hFF, 8'h00}};
	// PWM cases, period 8, high cycles over 80
	ptm_pwm_t pwm[6] = '{'{8'hA8, 16'h0003, 30}, '{8'hA8, 16'h000A, 80},
		'{8'h88, 16'h0003, 0}, '{8'h98, 16'h0003, 80},
		'{8'hAC, 16'h0003, 50}, '{8'hA0, 16'h0003, 50}};
	// Expected counts per clock source over 128 cycles
	int cexp[8] = '{32, 128, 4, 1, 8, 8, 6, 6};
	ptm_top u_dut (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .high_speed_tick(high_speed_tick),
		.sub_clock(sub_clock), .external_count_input(external_count_input),
		.timer_output(timer_output),
		.timer_output_inverted(timer_output_inverted),
		.compare_a_flag(compare_a_flag), .compare_p_flag(compare_p_flag));
	ptm_pins_model u_pins (.sys_clk(sys_clk), .rst(rst),
		.high_speed_tick(high_speed_tick), .sub_clock(sub_clock),
		.external_count_input(external_count_input));
	// ****
	// Clock, compare and bus tasks
	// ****
	initial
	begin
		sys_clk = 1'b0;
		forever #50 sys_clk = ~sys_clk;
	end
	task automatic chk_byte(input string nm, input logic [7:0] e,
		input logic [7:0] g);
		num_checks++;
		if (g !== e)
		begin
			n_errors++;
			$display("[ERR] %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic chk_num(input string nm, input int e, input int g);
		num_checks++;
		if (g != e)
		begin
			n_errors++;
			$display("[ERR] %s exp %0d got %0d", nm, e, g);
		end
	endtask
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask
	// Read data stands only in the cycle after the strobe
	task automatic rd(input logic [2:0] a, output logic [7:0] v);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1 v = reg_rdata;
	endtask
	// Timer is switched off around every mode or pin change
	task automatic setup(input logic [7:0] c1, input logic [15:0] a,
		input logic [15:0] p);
		wr(3'h0, 8'h00);
		wr(3'h1, c1);
		wr(3'h4, a[7:0]);
		wr(3'h5, a[15:8]);
		wr(3'h6, p[7:0]);
		wr(3'h7, p[15:8]);
		wr(3'h0, 8'h18);
		repeat (2) @(posedge sys_clk);
	endtask
	// Counts flags, pin highs and toggles; flags two wide count as bad
	task automatic watch(input int n);
		na = 0;
		np = 0;
		nhi = 0;
		ntg = 0;
		nbad = 0;
		po = timer_output;
		pa = 1'b0;
		pp = 1'b0;
		repeat (n)
		begin
			@(negedge sys_clk);
			na += compare_a_flag;
			np += compare_p_flag;
			nhi += timer_output;
			ntg += (timer_output !== po);
			nbad += (timer_output_inverted !== ~timer_output);
			nbad += (pa && compare_a_flag) + (pp && compare_p_flag);
			po = timer_output;
			pa = compare_a_flag;
			pp = compare_p_flag;
		end
	endtask
	task automatic summarize();
		if (n_errors == 0 && num_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// ****
	// Main sequence
	// ****
	initial
	begin
		rst = 1'b1;
		reg_addr = 3'h0;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		n_errors = 0;
		num_checks = 0;
		repeat (12) @(posedge sys_clk);
		rst <= 1'b0;
		for (int i = 0; i < 8; i++)
		begin
			rd(i[2:0], rv);
			chk_byte("reset value", 8'h00, rv);
		end
		foreach (rows[i])
		begin
			wr(rows[i].a, rows[i].d);
			rd(rows[i].a, rv);
			chk_byte("readback", rows[i].e, rv);
		end
		// Compare mode, P clears at 5, A toggles pin at 3
		setup(8'h30, 16'h0003, 16'h0005);
		watch(50);
		chk_num("p flags", 10, np);
		chk_num("a flags", 10, na);
		chk_num("toggles", 10, ntg);
		chk_num("bad pulses", 0, nbad);
		// A clears at 4 while P below it never flags
		setup(8'h31, 16'h0004, 16'h0002);
		watch(40);
		chk_num("a clear flags", 10, na);
		chk_num("p with a clear", 0, np);
		// Drive high on match, then on rising edge restores low
		setup(8'h20, 16'h0003, 16'h0006);
		watch(12);
		chk_byte("set high", 8'h01, {7'h00, timer_output});
		wr(3'h0, 8'h00);
		wr(3'h0, 8'h18);
		@(posedge sys_clk);
		@(negedge sys_clk);
		chk_byte("initial level", 8'h00, {7'h00, timer_output});
		setup(8'h10, 16'h0003, 16'h0006);
		watch(30);
		chk_num("same level", 0, ntg + nhi);
		setup(8'h0C, 16'h0003, 16'h0006);
		watch(10);
		chk_num("inverted", 0, nhi);
		setup(8'h08, 16'h0003, 16'h0006);
		watch(10);
		chk_num("non inverted", 10, nhi);
		foreach (pwm[i])
		begin
			setup(pwm[i].c1, pwm[i].a, 16'h0008);
			watch(80);
			chk_num("pwm high", pwm[i].hi, nhi);
		end
		// Single pulse: active from on edge until A match drops the on bit
		setup(8'hB8, 16'h0005, 16'h0008);
		watch(20);
		chk_num("pulse highs", 4, nhi);
		chk_num("pulse flags", 1, na);
		rd(3'h0, rv);
		chk_byte("pulse stops", 8'h10, rv);
		// Pause and off both hold the count; on clears it
		setup(8'hC0, 16'h0000, 16'h0000);
		wr(3'h0, 8'h98);
		rd(3'h2, rv);
		repeat (5) @(posedge sys_clk);
		rd(3'h2, rv2);
		chk_byte("paused", rv, rv2);
		wr(3'h0, 8'h18);
		rd(3'h2, rv2);
		chk_num("resumed", 1, rv2 > rv && rv2 < rv + 8'h08);
		wr(3'h0, 8'h10);
		rd(3'h2, rv);
		repeat (5) @(posedge sys_clk);
		rd(3'h2, rv2);
		chk_byte("off hold", rv, rv2);
		wr(3'h0, 8'h18);
		rd(3'h2, rv);
		chk_num("on clears", 1, rv < 8'h04);
		// Reset in mid-run clears a running counter and the control byte
		@(posedge sys_clk);
		rst <= 1'b1;
		repeat (2) @(posedge sys_clk);
		rst <= 1'b0;
		rd(3'h2, rv);
		chk_byte("reset count", 8'h00, rv);
		rd(3'h0, rv);
		chk_byte("reset ctrl0", 8'h00, rv);
		for (int i = 0; i < 8; i++)
		begin
			wr(3'h0, 8'h00);
			wr(3'h0, {1'b0, i[2:0], 4'h8});
			repeat (128) @(posedge sys_clk);
			rd(3'h2, rv);
			chk_num("clock rate", 1,
				int'(rv) >= cexp[i] - 1 && int'(rv) <= cexp[i] + 1);
		end
		summarize();
	end
	// Watchdog well past the expected run of a few thousand cycles
	initial
	begin
		#(100 * 60000);
		n_errors++;
		summarize();
	end
endmodule

/* File: tb/ptm_pins_model.sv */
`timescale 1ns/1ps
// ****
// Pin side: high clock strobe, sub clock and count pin
// ****
module ptm_pins_model (
	input wire logic sys_clk, // System clock
	input wire logic rst, // Sync reset, high
	output logic high_speed_tick, // Strobe every second cycle
	output logic sub_clock, // Period of 16 cycles
	output logic external_count_input // Period of 20 cycles
);
	logic [7:0] ph_r = 8'h00;
	// One phase counter; 80 is a multiple of every pin period
	always_ff @(posedge sys_clk)
	begin
		if (rst || ph_r == 8'h4F)
			ph_r <= 8'h00;
		else
			ph_r <= ph_r + 8'h01;
	end
	// Pins run whenever reset is low, so every clock source keeps getting edges
	assign high_speed_tick = ph_r[0];
	assign sub_clock = (ph_r % 8'h10) < 8'h08;
	assign external_count_input = (ph_r % 8'h14) < 8'h0A;
endmodule
